//--- src/dctim_top.sv
// dual channel capture timer with avalon register slave
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`default_nettype none
module dctim_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic channel0_pin_i,
  output logic channel0_pin_o,
  output logic channel0_pin_oe_o,
  input wire logic channel1_pin_i,
  output logic channel1_pin_o,
  output logic channel1_pin_oe_o,
  input wire logic external_timer_clock_pin_i,
  input wire logic [2:0] port_out_i,
  input wire logic [2:0] port_oe_i,
  output logic ovf_irq_o,
  output logic ch0_irq_o,
  output logic ch1_irq_o
);
  logic [7:0] ctrl_q;
  logic [15:0] count_q;
  logic [15:0] mod_q;
  logic [7:0] ch0_ctrl_q;
  logic [7:0] ch1_ctrl_q;
  logic [15:0] ch0_cmp_q;
  logic [15:0] ch1_cmp_q;
  logic [6:0] presc_q;
  logic [6:0] presc_prev_q;
  logic ext_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic buf_sel_q;
  logic buf_pend_q;
  logic tick;
  logic ovf_tick;
  logic [2:0] ps;
  logic linked;
  logic ev0;
  logic ev1;
  logic [15:0] cap0;
  logic [15:0] cap1;
  logic pin0_out;
  logic pin1_out;
  logic [15:0] cmp0_live;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] wmask;
  logic clr_ovf;
  logic clr_ch0;
  logic clr_ch1;

  // one-cycle acknowledge: waitrequest drops in the cycle after the request rises
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_acc = avs_write_i && !avs_waitrequest_o;
  assign rd_acc = avs_read_i && !avs_waitrequest_o;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  // prescaler: taps 0..6 give bus/1 .. bus/64, code 7 uses the external pin
  assign ps = ctrl_q[dctim_pkg::CTRL_PS_LSB +: 3];
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_q <= 7'h00;
      presc_prev_q <= 7'h00;
      ext_q <= 1'b0;
    end else begin
      presc_q <= ctrl_q[dctim_pkg::CTRL_RST] ? 7'h00 : presc_q + 7'h01;
      presc_prev_q <= presc_q;
      ext_q <= external_timer_clock_pin_i;
    end
  end

  always_comb begin
    if (ps == dctim_pkg::PS_EXT) begin
      tick = external_timer_clock_pin_i && !ext_q;
    end else if (ps == 3'h0) begin
      tick = 1'b1;
    end else begin
      tick = presc_q[ps - 3'h1] && !presc_prev_q[ps - 3'h1];
    end
    tick = tick && !ctrl_q[dctim_pkg::CTRL_STOP] && !ctrl_q[dctim_pkg::CTRL_RST];
  end

  assign ovf_tick = tick && (count_q == mod_q);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= dctim_pkg::CNT_ZERO;
    end else if (ctrl_q[dctim_pkg::CTRL_RST]) begin
      count_q <= dctim_pkg::CNT_ZERO;
    end else if (ovf_tick) begin
      count_q <= dctim_pkg::CNT_ZERO;
    end else if (tick) begin
      count_q <= count_q + dctim_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mod_q <= dctim_pkg::MOD_RESET;
    end else if (wr_acc && avs_address_i == dctim_pkg::ADDR_MOD) begin
      mod_q <= (mod_q & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
    end
  end

  // flags are cleared by writing one; a same-cycle event keeps the flag set
  assign clr_ovf = wr_acc && avs_address_i == dctim_pkg::ADDR_CTRL && avs_byteenable_i[0] &&
    avs_writedata_i[dctim_pkg::CTRL_OVF];
  assign clr_ch0 = wr_acc && avs_address_i == dctim_pkg::ADDR_CH0_CTRL && avs_byteenable_i[0] &&
    avs_writedata_i[dctim_pkg::CH_FLAG];
  assign clr_ch1 = wr_acc && avs_address_i == dctim_pkg::ADDR_CH1_CTRL && avs_byteenable_i[0] &&
    avs_writedata_i[dctim_pkg::CH_FLAG];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= dctim_pkg::CTRL_RESET[7:0];
    end else begin
      if (wr_acc && avs_address_i == dctim_pkg::ADDR_CTRL && avs_byteenable_i[0]) begin
        ctrl_q[6:0] <= avs_writedata_i[6:0];
      end
      if (ovf_tick) begin
        ctrl_q[dctim_pkg::CTRL_OVF] <= 1'b1;
      end else if (clr_ovf) begin
        ctrl_q[dctim_pkg::CTRL_OVF] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch0_ctrl_q <= 8'h00;
      ch1_ctrl_q <= 8'h00;
    end else begin
      if (wr_acc && avs_address_i == dctim_pkg::ADDR_CH0_CTRL && avs_byteenable_i[0]) begin
        ch0_ctrl_q[6:0] <= avs_writedata_i[6:0];
      end
      if (wr_acc && avs_address_i == dctim_pkg::ADDR_CH1_CTRL && avs_byteenable_i[0]) begin
        ch1_ctrl_q[6:0] <= avs_writedata_i[6:0];
      end
      if (ev0) begin
        ch0_ctrl_q[dctim_pkg::CH_FLAG] <= 1'b1;
      end else if (clr_ch0) begin
        ch0_ctrl_q[dctim_pkg::CH_FLAG] <= 1'b0;
      end
      if (ev1) begin
        ch1_ctrl_q[dctim_pkg::CH_FLAG] <= 1'b1;
      end else if (clr_ch1) begin
        ch1_ctrl_q[dctim_pkg::CH_FLAG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch0_cmp_q <= dctim_pkg::CNT_ZERO;
      ch1_cmp_q <= dctim_pkg::CNT_ZERO;
    end else if (wr_acc) begin
      if (avs_address_i == dctim_pkg::ADDR_CH0_VAL) begin
        ch0_cmp_q <= (ch0_cmp_q & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
      end
      if (avs_address_i == dctim_pkg::ADDR_CH1_VAL) begin
        ch1_cmp_q <= (ch1_cmp_q & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
      end
    end
  end

  // buffered link: pending selection remembers which set was written last
  assign linked = ch0_ctrl_q[dctim_pkg::CH_LINK];
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_sel_q <= 1'b0;
      buf_pend_q <= 1'b0;
    end else if (!linked) begin
      buf_sel_q <= 1'b0;
      buf_pend_q <= 1'b0;
    end else begin
      if (wr_acc && avs_address_i == dctim_pkg::ADDR_CH1_VAL) begin
        buf_pend_q <= 1'b1;
      end else if (wr_acc && avs_address_i == dctim_pkg::ADDR_CH0_VAL) begin
        buf_pend_q <= 1'b0;
      end
      if (ovf_tick) begin
        buf_sel_q <= buf_pend_q;
      end
    end
  end

  assign cmp0_live = (linked && buf_sel_q) ? ch1_cmp_q : ch0_cmp_q;

  dctim_channel u_ch0 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .ovf_i(ovf_tick),
    .count_i(count_q),
    .cmp_val_i(cmp0_live),
    .capture_mode_i(!linked && !ch0_ctrl_q[dctim_pkg::CH_MODE]),
    .edge_sel_i(ch0_ctrl_q[dctim_pkg::CH_ELS_LSB +: 2]),
    .tov_i(ch0_ctrl_q[dctim_pkg::CH_TOV]),
    .enable_i(1'b1),
    .pin_i(channel0_pin_i),
    .event_o(ev0),
    .cap_val_o(cap0),
    .pin_o(pin0_out)
  );

  dctim_channel u_ch1 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .ovf_i(ovf_tick),
    .count_i(count_q),
    .cmp_val_i(ch1_cmp_q),
    .capture_mode_i(!ch1_ctrl_q[dctim_pkg::CH_MODE]),
    .edge_sel_i(ch1_ctrl_q[dctim_pkg::CH_ELS_LSB +: 2]),
    .tov_i(ch1_ctrl_q[dctim_pkg::CH_TOV]),
    .enable_i(!linked),
    .pin_i(channel1_pin_i),
    .event_o(ev1),
    .cap_val_o(cap1),
    .pin_o(pin1_out)
  );

  // pins fall back to the port when the timer does not drive them
  always_comb begin
    if (ch0_ctrl_q[dctim_pkg::CH_MODE] || linked) begin
      channel0_pin_o = pin0_out;
      channel0_pin_oe_o = 1'b1;
    end else begin
      channel0_pin_o = port_out_i[0];
      channel0_pin_oe_o = port_oe_i[0];
    end
    if (ch1_ctrl_q[dctim_pkg::CH_MODE] && !linked) begin
      channel1_pin_o = pin1_out;
      channel1_pin_oe_o = 1'b1;
    end else begin
      channel1_pin_o = port_out_i[1];
      channel1_pin_oe_o = port_oe_i[1];
    end
  end

  assign ovf_irq_o = ctrl_q[dctim_pkg::CTRL_OVF] && ctrl_q[dctim_pkg::CTRL_OVIE];
  assign ch0_irq_o = ch0_ctrl_q[dctim_pkg::CH_FLAG] && ch0_ctrl_q[dctim_pkg::CH_IE];
  assign ch1_irq_o = ch1_ctrl_q[dctim_pkg::CH_FLAG] && ch1_ctrl_q[dctim_pkg::CH_IE];

  // reads have no side effects, so sampling the counter never disturbs it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      case (avs_address_i)
        dctim_pkg::ADDR_CTRL: rdata_q <= {24'h000000, ctrl_q};
        dctim_pkg::ADDR_CNT: rdata_q <= {16'h0000, count_q};
        dctim_pkg::ADDR_MOD: rdata_q <= {16'h0000, mod_q};
        dctim_pkg::ADDR_CH0_CTRL: rdata_q <= {24'h000000, ch0_ctrl_q};
        dctim_pkg::ADDR_CH0_VAL: rdata_q <= {16'h0000,
          ch0_ctrl_q[dctim_pkg::CH_MODE] || linked ? ch0_cmp_q : cap0};
        dctim_pkg::ADDR_CH1_CTRL: rdata_q <= {24'h000000, ch1_ctrl_q};
        dctim_pkg::ADDR_CH1_VAL: rdata_q <= {16'h0000,
          ch1_ctrl_q[dctim_pkg::CH_MODE] || linked ? ch1_cmp_q : cap1};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_o = rdata_q;

  AST_WRAP_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ovf_tick |=> count_q == dctim_pkg::CNT_ZERO)
    else $error("counter did not wrap to zero");
  AST_STOP_HOLDS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ctrl_q[dctim_pkg::CTRL_STOP] && !ctrl_q[dctim_pkg::CTRL_RST] |=> $stable(count_q))
    else $error("stopped counter moved");
  AST_OVF_FLAG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ovf_tick |=> ctrl_q[dctim_pkg::CTRL_OVF])
    else $error("overflow flag not set");
  AST_CH_FLAG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ev0 |=> ch0_ctrl_q[dctim_pkg::CH_FLAG])
    else $error("channel flag not set");
  AST_BUF_SWAP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    linked && ovf_tick && buf_pend_q |=> buf_sel_q)
    else $error("buffered set did not switch");
  AST_COUNT_UP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tick && !ovf_tick |=> count_q == $past(count_q) + dctim_pkg::CNT_ONE)
    else $error("counter did not step");
  AST_READ_ACK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read not answered in one cycle");
  AST_CH1_FREED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    linked |-> channel1_pin_o == port_out_i[1] && !ev1)
    else $error("channel one pin not freed while linked");
endmodule
`default_nettype wire

//--- pkg/dctim_pkg.sv
// constants, register map and types for the dual channel capture timer
`default_nettype none
package dctim_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CNT = 4'h1;
  localparam logic [3:0] ADDR_MOD = 4'h2;
  localparam logic [3:0] ADDR_CH0_CTRL = 4'h3;
  localparam logic [3:0] ADDR_CH0_VAL = 4'h4;
  localparam logic [3:0] ADDR_CH1_CTRL = 4'h5;
  localparam logic [3:0] ADDR_CH1_VAL = 4'h6;
  localparam logic [15:0] MOD_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // timer control register fields
  localparam int CTRL_PS_LSB = 0;
  localparam int CTRL_RST = 4;
  localparam int CTRL_STOP = 5;
  localparam int CTRL_OVIE = 6;
  localparam int CTRL_OVF = 7;
  localparam logic [2:0] PS_EXT = 3'h7;
  // channel control register fields
  localparam int CH_TOV = 0;
  localparam int CH_ELS_LSB = 2;
  localparam int CH_MODE = 4;
  localparam int CH_LINK = 5;
  localparam int CH_IE = 6;
  localparam int CH_FLAG = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
  typedef enum logic [1:0] {
    DCTIM_ACT_NONE,
    DCTIM_ACT_TOGGLE,
    DCTIM_ACT_CLEAR,
    DCTIM_ACT_SET
  } dctim_act_e;
endpackage
`default_nettype wire

//--- src/dctim_channel.sv
// one capture / compare channel with its pin logic
`default_nettype none
module dctim_channel (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic ovf_i,
  input wire logic [15:0] count_i,
  input wire logic [15:0] cmp_val_i,
  input wire logic capture_mode_i,
  input wire logic [1:0] edge_sel_i,
  input wire logic tov_i,
  input wire logic enable_i,
  input wire logic pin_i,
  output logic event_o,
  output logic [15:0] cap_val_o,
  output logic pin_o
);
  logic pin_q;
  logic rise;
  logic fall;
  logic cap_hit;
  logic cmp_hit;
  dctim_pkg::dctim_act_e act;

  assign act = dctim_pkg::dctim_act_e'(edge_sel_i);
  assign rise = pin_i && !pin_q;
  assign fall = !pin_i && pin_q;
  // edge select: 1 rising, 2 falling, 3 either; 0 disables capture
  assign cap_hit = enable_i && capture_mode_i &&
    ((edge_sel_i[0] && rise) || (edge_sel_i[1] && fall));
  // compare looks only at the live value, so a passed new value misses this period
  assign cmp_hit = enable_i && !capture_mode_i && tick_i && (count_i == cmp_val_i);
  assign event_o = cap_hit || cmp_hit;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_val_o <= dctim_pkg::CNT_ZERO;
    end else if (cap_hit) begin
      cap_val_o <= count_i;
    end
  end

  // compare action wins over the overflow toggle when both land together
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
    end else if (cmp_hit) begin
      case (act)
        dctim_pkg::DCTIM_ACT_TOGGLE: pin_o <= !pin_o;
        dctim_pkg::DCTIM_ACT_CLEAR: pin_o <= 1'b0;
        dctim_pkg::DCTIM_ACT_SET: pin_o <= 1'b1;
        default: pin_o <= pin_o;
      endcase
    end else if (enable_i && !capture_mode_i && ovf_i && tov_i) begin
      pin_o <= !pin_o;
    end
  end

  AST_CAPTURE_VALUE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cap_hit |=> cap_val_o == $past(count_i))
    else $error("capture did not latch the counter");
  AST_TOV_TOGGLE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (enable_i && !capture_mode_i && ovf_i && tov_i && !cmp_hit) |=> pin_o != $past(pin_o))
    else $error("overflow toggle missing");
endmodule
`default_nettype wire

//--- tb/dctim_pins.sv
// far-side pin model: event sources on the channel pins and the external clock
`default_nettype none
module dctim_pins (
  input wire logic core_clk_i,
  input wire logic [1:0] oe_i,
  input wire logic [1:0] drv_i,
  output logic [1:0] pin_o,
  output logic ext_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lvl_q = 2'h0;
  // a pin the timer or port drives shows that driver, otherwise the source level
  assign pin_o = (oe_i & drv_i) | (~oe_i & lvl_q);
  initial ext_clk_o = 1'b0;
  task automatic drive(input int ch, input logic v);
    @(posedge core_clk_i);
    lvl_q[ch] <= v;
    repeat (4) @(posedge core_clk_i);
  endtask
  // slow pulses so a synchroniser sees every edge; the line idles low between bursts
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (3) @(posedge core_clk_i);
      ext_clk_o <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      ext_clk_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- tb/dctim_top_test.sv
// self-checking bench for the dual channel capture timer
`default_nettype none
module dctim_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [1:0] pin_in;
  wire logic [1:0] pin_out;
  wire logic [1:0] pin_oe;
  logic ext_clk;
  logic [2:0] port_out = 3'h0;
  logic [2:0] port_oe = 3'h0;
  wire logic [2:0] irq;
  logic [31:0] q;
  logic [31:0] c1;
  logic p;
  int failures = 0;
  int checked = 0;
  int hi_n = 0;
  int hi_last = 0;
  int m;
  int k;
  int a;
  int w1;
  always #20 core_clk_i = ~core_clk_i;
  dctim_top u_dctim_top (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .avs_address_i(adr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq),
    .channel0_pin_i(pin_in[0]),
    .channel0_pin_o(pin_out[0]),
    .channel0_pin_oe_o(pin_oe[0]),
    .channel1_pin_i(pin_in[1]),
    .channel1_pin_o(pin_out[1]),
    .channel1_pin_oe_o(pin_oe[1]),
    .external_timer_clock_pin_i(ext_clk),
    .port_out_i(port_out),
    .port_oe_i(port_oe),
    .ovf_irq_o(irq[2]),
    .ch0_irq_o(irq[0]),
    .ch1_irq_o(irq[1])
  );
  dctim_pins u_dctim_pins (
    .core_clk_i(core_clk_i),
    .oe_i(pin_oe),
    .drv_i(pin_out),
    .pin_o(pin_in),
    .ext_clk_o(ext_clk)
  );
  // length of the last high pulse on pin 0, in clock cycles
  always @(posedge core_clk_i) begin
    if (pin_out[0] === 1'b1) hi_n <= hi_n + 1;
    else if (hi_n != 0) begin
      hi_last <= hi_n;
      hi_n <= 0;
    end
  end
  task automatic give_verdict();
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    adr <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) failures++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wctl(input logic [31:0] d);
    bus(1'b1, dctim_pkg::ADDR_CTRL, d);
  endtask
  task automatic rcnt();
    bus(1'b0, dctim_pkg::ADDR_CNT, 32'h0);
    c1 = q;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  function automatic logic [3:0] ca(input int ch);
    return ch ? dctim_pkg::ADDR_CH1_CTRL : dctim_pkg::ADDR_CH0_CTRL;
  endfunction
  // counter is parked at a known value, so the capture must copy exactly that
  task automatic cap_step(input int ch, input logic [1:0] e, input logic v);
    logic f;
    bus(1'b1, ca(ch), 32'hC0 | (32'(e) << 2));
    wctl(32'h00);
    wctl(32'h20);
    rcnt();
    u_dctim_pins.drive(ch, v);
    bus(1'b0, ca(ch), 32'h0);
    f = q[7];
    chk("capture flag", f, v ? e[0] : e[1]);
    chk("capture irq", irq[ch], f);
    bus(1'b0, ca(ch) + 4'h1, 32'h0);
    if (f) chk("capture value", q, c1);
  endtask
  initial begin
    #(40 * 20000);
    failures++;
    give_verdict();
  end
  initial begin
    void'($urandom(37));
    cyc(20);
    rst_n_i <= 1'b1;
    cyc(1);
    bus(1'b0, dctim_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", q, dctim_pkg::CTRL_RESET);
    bus(1'b0, dctim_pkg::ADDR_MOD, 32'h0);
    chk("modulo reset", q, {16'h0, dctim_pkg::MOD_RESET});
    rcnt();
    chk("count reset", q, 32'h0);
    bus(1'b1, 4'hA, 32'h55);
    bus(1'b0, 4'hA, 32'h0);
    chk("unmapped", q, 32'h0);
    for (int n = 0; n < 7; n++) begin
      wctl(32'h10 | 32'(n));
      wctl(32'(n));
      rcnt();
      cyc((8 << n) - 3);
      bus(1'b0, dctim_pkg::ADDR_CNT, 32'h0);
      chk("prescale", (q - c1) & 32'hFFFF, 32'h8);
    end
    wctl(32'h17);
    wctl(32'h07);
    rcnt();
    u_dctim_pins.ext_pulses(5);
    bus(1'b0, dctim_pkg::ADDR_CNT, 32'h0);
    chk("ext clock", (q - c1) & 32'hFFFF, 32'h5);
    m = 20 + $urandom % 40;
    k = $urandom % 50;
    bus(1'b1, dctim_pkg::ADDR_MOD, 32'(m));
    wctl(32'h50);
    wctl(32'h40);
    cyc(m + 2);
    rcnt();
    cyc(k);
    bus(1'b0, dctim_pkg::ADDR_CNT, 32'h0);
    chk("wrap", q, (c1 + 32'(3 + k)) % 32'(m + 1));
    chk("ovf irq", irq[2], 1'b1);
    wctl(32'h60);
    wctl(32'hE0);
    bus(1'b0, dctim_pkg::ADDR_CTRL, 32'h0);
    chk("ovf clear", {q[7:0], irq[2]}, 9'h0C0);
    for (int ch = 0; ch < 2; ch++) begin
      for (int e = 1; e < 4; e++) begin
        cap_step(ch, 2'(e), 1'b1);
        cap_step(ch, 2'(e), 1'b0);
      end
    end
    // the random modulo above may sit below the compare values drawn next
    bus(1'b1, dctim_pkg::ADDR_MOD, 32'hFFFF);
    for (int ch = 0; ch < 2; ch++) begin
      p = 1'bx;
      for (int act = 3; act > 0; act--) begin
        a = 10 + $urandom % 30;
        wctl(32'h30);
        bus(1'b1, ca(ch) + 4'h1, 32'(a));
        bus(1'b1, ca(ch), 32'h90 | 32'(act << 2));
        wctl(32'h00);
        cyc(a - 6);
        if (act < 3) chk("pin before match", pin_out[ch], p);
        cyc(10);
        p = act == 3 ? 1'b1 : act == 2 ? 1'b0 : !p;
        chk("pin after match", {pin_oe[ch], pin_out[ch]}, {1'b1, p});
        wctl(32'h20);
        bus(1'b0, ca(ch), 32'h0);
        chk("compare flag", {q[7], irq[ch]}, 2'b10);
      end
    end
    bus(1'b1, dctim_pkg::ADDR_MOD, 32'hFF);
    bus(1'b1, dctim_pkg::ADDR_CH0_VAL, 32'hC8);
    bus(1'b1, dctim_pkg::ADDR_CH0_CTRL, 32'h98);
    wctl(32'h30);
    wctl(32'h00);
    cyc(60);
    bus(1'b1, dctim_pkg::ADDR_CH0_VAL, 32'h14);
    cyc(150);
    wctl(32'h20);
    bus(1'b0, dctim_pkg::ADDR_CH0_CTRL, 32'h0);
    chk("passed value", q[7], 1'b0);
    wctl(32'h00);
    cyc(100);
    bus(1'b0, dctim_pkg::ADDR_CH0_CTRL, 32'h0);
    chk("new value", q[7], 1'b1);
    // compare just fired, so a smaller value written now waits for the next period
    bus(1'b1, dctim_pkg::ADDR_CH0_VAL, 32'h0A);
    bus(1'b1, dctim_pkg::ADDR_CH0_CTRL, 32'h98);
    cyc(100);
    bus(1'b0, dctim_pkg::ADDR_CH0_CTRL, 32'h0);
    chk("smaller early", q[7], 1'b0);
    cyc(110);
    bus(1'b0, dctim_pkg::ADDR_CH0_CTRL, 32'h0);
    chk("smaller value", q[7], 1'b1);
    // a counter reset stands in for the start of a fresh period
    wctl(32'h30);
    bus(1'b1, dctim_pkg::ADDR_CH0_VAL, 32'h80);
    bus(1'b1, dctim_pkg::ADDR_CH0_CTRL, 32'h98);
    wctl(32'h00);
    cyc(100);
    bus(1'b0, dctim_pkg::ADDR_CH0_CTRL, 32'h0);
    chk("larger early", q[7], 1'b0);
    cyc(60);
    bus(1'b0, dctim_pkg::ADDR_CH0_CTRL, 32'h0);
    chk("larger value", q[7], 1'b1);
    bus(1'b1, dctim_pkg::ADDR_MOD, 32'h3F);
    a = 10 + $urandom % 20;
    k = a + 5 + $urandom % 20;
    bus(1'b1, dctim_pkg::ADDR_CH0_VAL, 32'(a));
    bus(1'b1, dctim_pkg::ADDR_CH0_CTRL, 32'h39);
    port_out <= 3'($urandom);
    port_oe <= 3'($urandom);
    wctl(32'h10);
    wctl(32'h00);
    cyc(200);
    w1 = hi_last;
    bus(1'b1, dctim_pkg::ADDR_CH1_VAL, 32'(k));
    cyc(200);
    chk("buffered ch1", 32'(hi_last - w1), 32'(k - a));
    bus(1'b1, dctim_pkg::ADDR_CH0_VAL, 32'(a + 3));
    cyc(200);
    chk("buffered ch0", 32'(hi_last - w1), 32'h3);
    chk("freed pin", {pin_oe[1], pin_oe[1] & pin_out[1]},
        {port_oe[1], port_oe[1] & port_out[1]});
    give_verdict();
  end
endmodule
`default_nettype wire
